// ---- rtl/nv_access_pkg.sv ----
// Operation
// - 12-bit address split high/low; upper nibble of high reads zero.
// - Data register feeds writes and holds the byte after a read.
// - Mode 00 erase+program 3.4 ms, 01 erase 1.8 ms, 10 program 1.8 ms.
// - Mode field writes are ignored while program-enable is set.
// - Reset forces mode to 00 unless programming is in progress.
// - Ready interrupt level: enabled, global flag set, program-enable clear.
// - Program-enable starts a write only within four cycles of master-enable.
// - Hardware clears master-enable four cycles after software sets it.
// - No array programming while the CPU writes code memory.
// - Hardware clears program-enable when the programming time has elapsed.
// - Starting a write stalls the CPU for two cycles.
// - Read-enable fetches the addressed byte into the data register at once.
// - Starting a read stalls the CPU for four cycles.
// - During programming reads are refused and address changes blocked.
// - Control register bits 7:6 are reserved and read zero.
package nv_access_pkg;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 8;
    localparam int          DEPTH          = 4096;
    localparam logic [7:0]  OFS_CONTROL    = 8'h1F;
    localparam logic [7:0]  OFS_DATA       = 8'h20;
    localparam logic [7:0]  OFS_ADDR_LO    = 8'h21;
    localparam logic [7:0]  OFS_ADDR_HI    = 8'h22;
    localparam logic [7:0]  OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h31;
    localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h32;
    localparam int          BIT_READ       = 0;
    localparam int          BIT_PROG       = 1;
    localparam int          BIT_MASTER     = 2;
    localparam int          BIT_RDY_IE     = 3;
    localparam int          BIT_MODE_LO    = 4;
    localparam int          BIT_MODE_HI    = 5;
    localparam logic [1:0]  MODE_ATOMIC    = 2'h0;
    localparam logic [1:0]  MODE_ERASE     = 2'h1;
    localparam logic [1:0]  MODE_WRITE     = 2'h2;
    localparam logic [1:0]  MODE_RESERVED  = 2'h3;
    localparam logic [DATA_W-1:0] ERASED   = 8'hFF;
    localparam int          MASTER_CYCLES  = 4;
    localparam int          WRITE_STALL    = 2;
    localparam int          READ_STALL     = 4;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          T_ATOMIC_US    = 3400;
    localparam int          T_SPLIT_US     = 1800;
    localparam int          CYC_ATOMIC     = T_ATOMIC_US * (CLK_HZ / 1_000_000);
    localparam int          CYC_SPLIT      = T_SPLIT_US * (CLK_HZ / 1_000_000);
    localparam int          TIMER_W        = 17;
    // interrupt event bits
    localparam int          EV_DONE        = 0;
    localparam int          EV_REFUSED     = 1;
    localparam int          EV_W           = 2;
endpackage

// ---- rtl/nv_array_mem.sv ----
`timescale 1ns/1ns
module nv_array_mem #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 8
) (
    input  wire logic              clock,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset: array contents are nonvolatile and undefined at power-up
    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ---- rtl/nv_access_control.sv ----
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module nv_access_control #(
    parameter int CYC_ATOMIC = nv_access_pkg::CYC_ATOMIC,
    parameter int CYC_SPLIT  = nv_access_pkg::CYC_SPLIT
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        global_irq_flag,
    input  wire logic        self_program_busy,
    output logic             cpu_stall,
    output logic             ready_irq,
    output logic             irq
);
    localparam int AW = nv_access_pkg::ADDR_W;
    localparam int DW = nv_access_pkg::DATA_W;
    localparam int TW = nv_access_pkg::TIMER_W;
    localparam int EW = nv_access_pkg::EV_W;

    ////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    ////////////////////////////////////////////////////////////////////////
    // external level inputs, two flops each
    // only the second flop of each pair feeds any logic
    logic gie_meta_ff;
    logic gie_ff;
    logic spm_meta_ff;
    logic spm_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gie_meta_ff <= 1'b0;
            gie_ff      <= 1'b0;
            spm_meta_ff <= 1'b0;
            spm_ff      <= 1'b0;
        end else begin
            gie_meta_ff <= global_irq_flag;
            gie_ff      <= gie_meta_ff;
            spm_meta_ff <= self_program_busy;
            spm_ff      <= spm_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STALL = 3'b010,
        ST_ACK   = 3'b100
    } bus_state_e;

    bus_state_e  state_ff;
    logic [2:0]  stall_cnt_ff;
    logic        lane0;
    logic        wr_ctl;
    logic        wr_data;
    logic        wr_alo;
    logic        wr_ahi;
    logic        wr_ien;
    logic        wr_iclr;
    logic        req;

    // writes act on the edge a request is taken; the master holds it until
    // waitrequest drops, and the later edges are not idle so nothing repeats
    assign req     = (avs_read | avs_write) && state_ff == ST_IDLE;
    assign lane0   = avs_write && avs_byteenable[0] && state_ff == ST_IDLE;
    assign wr_ctl  = lane0 && avs_address == nv_access_pkg::OFS_CONTROL;
    assign wr_data = lane0 && avs_address == nv_access_pkg::OFS_DATA;
    assign wr_alo  = lane0 && avs_address == nv_access_pkg::OFS_ADDR_LO;
    assign wr_ahi  = lane0 && avs_address == nv_access_pkg::OFS_ADDR_HI;
    assign wr_ien  = lane0 && avs_address == nv_access_pkg::OFS_IRQ_ENABLE;
    assign wr_iclr = lane0 && avs_address == nv_access_pkg::OFS_IRQ_CLEAR;

    ////////////////////////////////////////////////////////////////////////
    // control register state
    logic [1:0]    mode_ff;
    logic          rdy_ie_ff;
    logic          master_ff;
    logic [2:0]    master_cnt_ff;
    logic          prog_ff;
    logic [TW-1:0] timer_ff;
    logic [AW-1:0] addr_ff;
    logic [DW-1:0] data_ff;
    logic [DW-1:0] latched_ff;
    logic          read_pend_ff;
    logic          start_write;
    logic          start_read;
    logic          refused;
    logic          done;
    logic [DW-1:0] mem_rdata;
    logic [DW-1:0] prog_value;
    logic          mem_we;

    // a start needs a live master window; reserved mode and code-memory
    // writes block it so the array is never driven with a bad timing
    assign start_write = wr_ctl && avs_writedata[nv_access_pkg::BIT_PROG]
                         && !prog_ff && master_ff
                         && !spm_ff
                         && mode_ff != nv_access_pkg::MODE_RESERVED;
    assign start_read  = wr_ctl && avs_writedata[nv_access_pkg::BIT_READ]
                         && !prog_ff && !start_write;
    assign refused     = wr_ctl && avs_writedata[nv_access_pkg::BIT_READ]
                         && prog_ff;
    assign done        = prog_ff && timer_ff == '0;

    // mode bits survive a reset while programming is running, so they sit
    // on the synchronised reset only when idle
    // a start keeps the mode that chose its timer, so the commit matches it
    always_ff @(posedge clock) begin
        if (!rst_n && !prog_ff) begin
            mode_ff <= nv_access_pkg::MODE_ATOMIC;
        end else if (rst_n && wr_ctl && !prog_ff && !start_write) begin
            mode_ff <= avs_writedata[nv_access_pkg::BIT_MODE_HI:
                                     nv_access_pkg::BIT_MODE_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdy_ie_ff <= 1'b0;
        end else if (wr_ctl) begin
            rdy_ie_ff <= avs_writedata[nv_access_pkg::BIT_RDY_IE];
        end
    end

    // a write that sets master and program together opens no window, so
    // one stray write can never start a cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            master_ff     <= 1'b0;
            master_cnt_ff <= '0;
        end else if (wr_ctl && avs_writedata[nv_access_pkg::BIT_MASTER]
                     && !avs_writedata[nv_access_pkg::BIT_PROG]) begin
            master_ff     <= 1'b1;
            master_cnt_ff <= 3'(nv_access_pkg::MASTER_CYCLES - 1);
        end else if (start_write) begin
            master_ff     <= 1'b0;
        end else if (master_ff) begin
            if (master_cnt_ff == '0) begin
                master_ff <= 1'b0;
            end
            master_cnt_ff <= master_cnt_ff - 3'h1;
        end
    end

    // prog flag and timer live outside the bus reset so a reset during
    // programming does not abort the array cycle
    always_ff @(posedge clock) begin
        if (start_write) begin
            prog_ff  <= 1'b1;
            timer_ff <= (mode_ff == nv_access_pkg::MODE_ATOMIC)
                        ? TW'(CYC_ATOMIC - 1) : TW'(CYC_SPLIT - 1);
        end else if (done) begin
            prog_ff  <= 1'b0;
        end else if (prog_ff) begin
            timer_ff <= timer_ff - TW'(1);
        end else if (!rst_n) begin
            prog_ff  <= 1'b0;
            timer_ff <= '0;
        end
    end

    // address has no reset value; software must load it first
    always_ff @(posedge clock) begin
        if (!prog_ff) begin
            if (wr_alo) begin
                addr_ff[7:0] <= avs_writedata[7:0];
            end
            if (wr_ahi) begin
                addr_ff[AW-1:8] <= avs_writedata[AW-9:0];
            end
        end
    end

    // the latched byte rides through a reset with the timer, so a cut
    // reset cannot commit a cleared value at the end of the cycle
    always_ff @(posedge clock) begin
        if (start_write) begin
            latched_ff <= data_ff;
        end
    end

    // the array read port is registered, so the fetch lands one edge after
    // the strobe, well inside the four stall cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_pend_ff <= 1'b0;
        end else begin
            read_pend_ff <= start_read;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= '0;
        end else if (read_pend_ff) begin
            data_ff <= mem_rdata;
        end else if (wr_data) begin
            data_ff <= avs_writedata[DW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array: commit at end of the programming time
    // write-only mode can only clear bits, as the cells themselves do
    always_comb begin
        unique case (mode_ff)
            nv_access_pkg::MODE_ERASE: prog_value = nv_access_pkg::ERASED;
            nv_access_pkg::MODE_WRITE: prog_value = mem_rdata & latched_ff;
            default:                   prog_value = latched_ff;
        endcase
    end
    assign mem_we = done;

    nv_array_mem #(
        .ADDR_W (AW),
        .DATA_W (DW)
    ) u_mem (
        .clock (clock),
        .we    (mem_we),
        .addr  (addr_ff),
        .wdata (prog_value),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus answer with cpu stall
    // the answer is held back through the stall so the next access waits;
    // cpu_stall mirrors exactly those cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= ST_IDLE;
            stall_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_write) begin
                        state_ff     <= ST_STALL;
                        stall_cnt_ff <= 3'(nv_access_pkg::WRITE_STALL - 1);
                    end else if (start_read) begin
                        state_ff     <= ST_STALL;
                        stall_cnt_ff <= 3'(nv_access_pkg::READ_STALL - 1);
                    end else if (req) begin
                        state_ff <= ST_ACK;
                    end
                end
                ST_STALL: begin
                    if (stall_cnt_ff == '0) begin
                        state_ff <= ST_ACK;
                    end
                    stall_cnt_ff <= stall_cnt_ff - 3'h1;
                end
                ST_ACK: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) && state_ff != ST_ACK;
    assign cpu_stall       = state_ff == ST_STALL;

    ////////////////////////////////////////////////////////////////////////
    // interrupts: done and refused-read events
    logic [EW-1:0] ev_status_ff;
    logic [EW-1:0] ev_enable_ff;
    logic [EW-1:0] ev_set;

    assign ev_set = {refused, done};

    // a set in the clear cycle wins so no event is lost
    generate
        for (genvar i = 0; i < EW; i++) begin : g_ev
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ev_status_ff[i] <= 1'b0;
                end else if (ev_set[i]) begin
                    ev_status_ff[i] <= 1'b1;
                end else if (wr_iclr && avs_writedata[i]) begin
                    ev_status_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ev_enable_ff <= '0;
        end else if (wr_ien) begin
            ev_enable_ff <= avs_writedata[EW-1:0];
        end
    end

    assign irq       = |(ev_status_ff & ev_enable_ff);
    // ready is a level, not a pulse: it stays up for as long as idle
    assign ready_irq = rdy_ie_ff && gie_ff && !prog_ff;

    ////////////////////////////////////////////////////////////////////////
    // read data, registered on the request cycle
    // they stand from the answer edge until the next read is taken
    logic [7:0] ctl_view;

    assign ctl_view = {2'h0, mode_ff, rdy_ie_ff, master_ff, prog_ff,
                       1'b0};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && state_ff == ST_IDLE) begin
            unique case (avs_address)
                nv_access_pkg::OFS_CONTROL:
                    avs_readdata <= {24'h0, ctl_view};
                nv_access_pkg::OFS_DATA:
                    avs_readdata <= {24'h0, data_ff};
                nv_access_pkg::OFS_ADDR_LO:
                    avs_readdata <= {24'h0, addr_ff[7:0]};
                nv_access_pkg::OFS_ADDR_HI:
                    avs_readdata <= {28'h0, addr_ff[AW-1:8]};
                nv_access_pkg::OFS_IRQ_STATUS:
                    avs_readdata <= {30'h0, ev_status_ff};
                nv_access_pkg::OFS_IRQ_ENABLE:
                    avs_readdata <= {30'h0, ev_enable_ff};
                default:
                    avs_readdata <= 32'h0;
            endcase
        end
    end
endmodule

// ---- sim/nv_access_properties.sv ----
`timescale 1ns/1ns
module nv_access_properties #(
    parameter int CYC_ATOMIC = 32,
    parameter int CYC_SPLIT  = 16
) (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        global_irq_flag,
    input wire logic        self_program_busy,
    input wire logic        cpu_stall,
    input wire logic        ready_irq,
    input wire logic        irq
);
    localparam logic [7:0] CTL = nv_access_pkg::OFS_CONTROL;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // stall is counted from its first cycle; the answer follows it at once
    sequence s_write_stall;
        cpu_stall ##1 cpu_stall ##1 (!cpu_stall && !avs_waitrequest);
    endsequence
    sequence s_read_stall;
        cpu_stall [*4] ##1 (!cpu_stall && !avs_waitrequest);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_write_stall_two: assert property (
        $rose(cpu_stall) && avs_write && avs_address == CTL &&
        avs_writedata[1:0] == 2'h2 |-> s_write_stall)
        else $error("write start stall length wrong");
    a_read_stall_four: assert property (
        $rose(cpu_stall) && avs_write && avs_address == CTL &&
        avs_writedata[1:0] == 2'h1 |-> s_read_stall)
        else $error("read start stall length wrong");
    a_busy_not_ready: assert property (
        $rose(cpu_stall) && avs_writedata[1] |-> !ready_irq)
        else $error("ready interrupt while programming");
    a_global_gates_ready: assert property (
        !global_irq_flag [*4] |-> !ready_irq)
        else $error("ready interrupt without global flag");
    a_plain_read_ack: assert property (
        $rose(avs_read) |=> !avs_waitrequest)
        else $error("register read not answered next cycle");
    a_plain_write_ack: assert property (
        $rose(avs_write) && avs_address != CTL |=> !avs_waitrequest)
        else $error("register write not answered next cycle");
    a_stall_holds_wait: assert property (
        cpu_stall |-> avs_waitrequest)
        else $error("bus answered during a stall");
    a_ctl_reserved_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == CTL |->
        avs_readdata[7:6] == 2'h0 && !avs_readdata[0])
        else $error("control reserved bits not zero");
    a_addr_high_zero: assert property (
        avs_read && !avs_waitrequest &&
        avs_address == nv_access_pkg::OFS_ADDR_HI |->
        avs_readdata[7:4] == 4'h0)
        else $error("address high upper nibble not zero");
endmodule

bind nv_access_control nv_access_properties #(
    .CYC_ATOMIC(CYC_ATOMIC), .CYC_SPLIT(CYC_SPLIT)
) chk_u (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_irq_flag(global_irq_flag),
    .self_program_busy(self_program_busy), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq), .irq(irq)
);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    localparam int         CYC_A = 32;
    localparam int         CYC_S = 16;
    localparam logic [7:0] CTL   = nv_access_pkg::OFS_CONTROL;
    localparam logic [7:0] DAT   = nv_access_pkg::OFS_DATA;
    localparam logic [7:0] ALO   = nv_access_pkg::OFS_ADDR_LO;
    localparam logic [7:0] AHI   = nv_access_pkg::OFS_ADDR_HI;
    localparam logic [7:0] IST   = nv_access_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] IEN   = nv_access_pkg::OFS_IRQ_ENABLE;
    localparam logic [7:0] ICL   = nv_access_pkg::OFS_IRQ_CLEAR;
    logic        clock             = 1'h0;
    logic        reset_n           = 1'h0;
    logic [7:0]  avs_address       = 8'h00;
    logic        avs_read          = 1'h0;
    logic        avs_write         = 1'h0;
    logic [3:0]  avs_byteenable    = 4'hF;
    logic [31:0] avs_writedata     = 32'h0;
    logic        global_irq_flag   = 1'h1;
    logic        self_program_busy = 1'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cpu_stall;
    logic        ready_irq;
    logic        irq;
    logic [7:0]  q;
    int          n;
    int          fail_count        = 0;
    int          total_checks      = 0;

    always #25 clock = ~clock;

    nv_access_control #(.CYC_ATOMIC(CYC_A), .CYC_SPLIT(CYC_S)) dut_u (
        .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .global_irq_flag(global_irq_flag),
        .self_program_busy(self_program_busy), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .irq(irq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", fail_count, total_checks);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        finish_test();
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one request at a time; waitrequest is read at each edge before it moves
    task automatic bus_op(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'h0 && k < 200);
        q = avs_readdata[7:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (k >= 200) hang();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_op(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus_op(1'h0, a, 8'h00);
    endtask

    // keeps the ready interrupt enabled so completion can be timed on its pin
    task automatic start(input logic [1:0] m, input logic [7:0] d);
        global_irq_flag <= 1'h0;
        wr(DAT, d);
        wr(CTL, 8'h0C | {2'h0, m, 4'h0});
        wr(CTL, 8'h0A | {2'h0, m, 4'h0});
        global_irq_flag <= 1'h1;
    endtask

    task automatic wait_ready();
        n = 0;
        while (ready_irq !== 1'h1) begin
            if (n >= 500) hang();
            @(posedge clock);
            n++;
        end
    endtask

    task automatic do_reset(input int k);
        @(posedge clock);
        reset_n <= 1'h0;
        repeat (k) @(posedge clock);
        reset_n <= 1'h1;
        repeat (3) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        rd(DAT);
        check(q, 8'h00);
        rd(CTL);
        check(q, 8'h00);
        wr(AHI, 8'hFA);
        wr(ALO, 8'h10);
        rd(AHI);
        check(q, 8'h0A);
        rd(ALO);
        check(q, 8'h10);
        avs_byteenable <= 4'hE;
        wr(ALO, 8'h77);
        avs_byteenable <= 4'hF;
        rd(ALO);
        check(q, 8'h10);
        wr(8'h40, 8'hFF);
        rd(8'h40);
        rd(DAT);
        check(q, 8'h00);
    endtask

    task automatic s_modes();
        logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        logic [7:0] dv [4] = '{8'hA5, 8'h00, 8'h3C, 8'h0F};
        logic [7:0] ev [4] = '{8'hA5, 8'hFF, 8'h3C, 8'h0C};
        int cyc;
        for (int i = 0; i < 4; i++) begin
            start(md[i], dv[i]);
            wait_ready();
            cyc = (md[i] == 2'h0) ? CYC_A : CYC_S;
            // ready shows one edge after the timer ends; counting starts
            // three edges after the start is taken
            check(8'(n), 8'(cyc - 2));
            wr(CTL, 8'h09);
            rd(DAT);
            check(q, ev[i]);
        end
    endtask

    task automatic s_busy();
        start(2'h0, 8'h77);
        wr(CTL, 8'h2A);
        wr(ALO, 8'h55);
        wr(CTL, 8'h09);
        wait_ready();
        rd(CTL);
        check(q, 8'h08);
        rd(ALO);
        check(q, 8'h10);
        rd(DAT);
        check(q, 8'h77);
        rd(IST);
        check(q, 8'h03);
        wr(ICL, 8'h03);
        rd(IST);
        check(q, 8'h00);
        wr(CTL, 8'h09);
        rd(DAT);
        check(q, 8'h77);
    endtask

    task automatic s_window();
        wr(CTL, 8'h0C);
        rd(CTL);
        check(q & 8'h04, 8'h04);
        repeat (5) @(posedge clock);
        rd(CTL);
        check(q & 8'h04, 8'h00);
        wr(CTL, 8'h0A);
        rd(CTL);
        check(q & 8'h02, 8'h00);
        self_program_busy <= 1'h1;
        repeat (3) @(posedge clock);
        start(2'h0, 8'h11);
        rd(CTL);
        check(q & 8'h02, 8'h00);
        self_program_busy <= 1'h0;
        start(2'h3, 8'h11);
        rd(CTL);
        check(q & 8'h02, 8'h00);
        wr(CTL, 8'h09);
        rd(DAT);
        check(q, 8'h77);
    endtask

    task automatic s_irq();
        wr(IEN, 8'h01);
        start(2'h0, 8'h5A);
        wait_ready();
        @(posedge clock);
        check({7'h0, irq}, 8'h01);
        wr(IEN, 8'h00);
        @(posedge clock);
        check({7'h0, irq}, 8'h00);
        wr(IEN, 8'h01);
        @(posedge clock);
        check({7'h0, irq}, 8'h01);
        wr(ICL, 8'h01);
        @(posedge clock);
        check({7'h0, irq}, 8'h00);
        global_irq_flag <= 1'h0;
        repeat (4) @(posedge clock);
        check({7'h0, ready_irq}, 8'h00);
        global_irq_flag <= 1'h1;
        repeat (4) @(posedge clock);
        check({7'h0, ready_irq}, 8'h01);
        wr(CTL, 8'h00);
        @(posedge clock);
        check({7'h0, ready_irq}, 8'h00);
    endtask

    // a reset in mid-write must leave the running mode alone
    task automatic s_reset();
        start(2'h2, 8'hF0);
        do_reset(2);
        rd(CTL);
        check(q & 8'h30, 8'h20);
        n = 0;
        do begin
            rd(CTL);
            n++;
        end while (q[1] !== 1'h0 && n < 100);
        if (n >= 100) hang();
        wr(CTL, 8'h01);
        rd(DAT);
        check(q, 8'h50);
        do_reset(4);
        rd(CTL);
        check(q, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'h1;
        repeat (3) @(posedge clock);
        s_regs();
        s_modes();
        s_busy();
        s_window();
        s_irq();
        s_reset();
        finish_test();
    end
endmodule
